// ==== lbs_pkg.sv ====
// Purpose: constants for the ladder boolean stack evaluator
// Assumes: one scan clock, opcodes issued by the program sequencer
// Notes:   opcode values and phase codes are local encodings
//
// What this block does
// - end instruction stops the main program
// - load contact pushes the image bit
// - inverted load pushes the complemented bit
// - every load after the first of a rung pushes, older levels move down
// - eight levels maximum; overflow raises error
// - series combine ANDs top two levels
// - parallel combine ORs top two levels
// - series contact ANDs into rung result
// - parallel contact ORs into rung result
// - rung continues after a coil
// - ordinary I/O moves only in update phases
// - immediate read bypasses, image stays unchanged
// - later immediates fetch the module again
// - immediate output writes module and image
// - execution stalls during immediate access
package lbs_pkg;

    // default sizes
    localparam int STACK_LEVELS = 8;
    localparam int IMG_BITS     = 256;
    localparam int NUM_IN       = 64;
    localparam int NUM_OUT      = 64;
    localparam int ADDR_W       = 8;

    // reset values
    localparam logic RST_LOW  = 1'b0;
    localparam logic RST_HIGH = 1'b1;

    // scan phase codes, driven by the scan sequencer
    typedef enum logic [1:0] {
        LBS_PH_IN_UPD  = 2'h0,
        LBS_PH_EXEC    = 2'h1,
        LBS_PH_OUT_UPD = 2'h3,
        LBS_PH_IDLE    = 2'h2
    } lbs_phase_t;

    // instruction opcodes
    typedef enum logic [3:0] {
        LBS_OP_NOP                     = 4'h0,
        LBS_OP_LOAD_CONTACT            = 4'h1,
        LBS_OP_LOAD_INVERTED_CONTACT   = 4'h2,
        LBS_OP_AND                     = 4'h3,
        LBS_OP_AND_NOT                 = 4'h4,
        LBS_OP_OR                      = 4'h5,
        LBS_OP_OR_NOT                  = 4'h6,
        LBS_OP_COMBINE_SERIES_LEVELS   = 4'h7,
        LBS_OP_COMBINE_PARALLEL_LEVELS = 4'h8,
        LBS_OP_OUT                     = 4'h9,
        LBS_OP_LOAD_IMM                = 4'hA,
        LBS_OP_LOAD_INVERTED_IMM       = 4'hB,
        LBS_OP_AND_IMM                 = 4'hC,
        LBS_OP_OR_IMM                  = 4'hD,
        LBS_OP_OUT_IMM                 = 4'hE,
        LBS_OP_END                     = 4'hF
    } lbs_op_t;

    // immediate access sequencer, gray along idle -> wait
    typedef enum logic [0:0] {
        LBS_ST_IDLE = 1'h0,
        LBS_ST_WAIT = 1'h1
    } lbs_state_t;

endpackage

// ==== lbs_evaluator.sv ====
// Purpose: boolean stack evaluator for ladder contacts, coils and immediates
// Assumes: image register held here; module port logic shares clk
// Notes:   io_in is a pin group and is synchronised; imm_* are not
`timescale 1ns/100ps

module lbs_evaluator #(
    parameter int STACK_LEVELS = lbs_pkg::STACK_LEVELS,
    parameter int IMG_BITS     = lbs_pkg::IMG_BITS,
    parameter int NUM_IN       = lbs_pkg::NUM_IN,
    parameter int NUM_OUT      = lbs_pkg::NUM_OUT,
    parameter int ADDR_W       = lbs_pkg::ADDR_W
) (
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst_b,
    // scan sequencer
    input  wire lbs_pkg::lbs_phase_t  phase,
    // instruction stream
    input  wire logic                 instr_valid,
    input  wire lbs_pkg::lbs_op_t     instr_op,
    input  wire logic [ADDR_W-1:0]    instr_addr,
    input  wire logic                 instr_isr,
    output      logic                 instr_ready,
    // status
    output      logic                 rung_result,
    output      logic                 stack_err,
    output      logic                 prog_done,
    // ordinary I/O pins
    input  wire logic [NUM_IN-1:0]    io_in,
    output      logic [NUM_OUT-1:0]   io_out,
    // immediate module access
    output      logic                 imm_req,
    output      logic                 imm_wr,
    output      logic [ADDR_W-1:0]    imm_addr,
    output      logic                 imm_wdata,
    input  wire logic                 imm_ack,
    input  wire logic                 imm_rdata
);
    import lbs_pkg::*;

    localparam int DEPTH_W = $clog2(STACK_LEVELS + 1);
    localparam logic [DEPTH_W-1:0] DEPTH_MAX  = DEPTH_W'(STACK_LEVELS);
    localparam logic [DEPTH_W-1:0] DEPTH_ZERO = '0;
    localparam logic [DEPTH_W-1:0] DEPTH_ONE  = DEPTH_W'(1);

    // contact value, optionally inverted
    function automatic logic contact(input logic val, input logic inv);
        contact = inv ? ~val : val;
    endfunction

    // true for the opcodes that go out to the module
    function automatic logic is_imm(input lbs_op_t op);
        is_imm = (op == LBS_OP_LOAD_IMM) || (op == LBS_OP_LOAD_INVERTED_IMM) ||
                 (op == LBS_OP_AND_IMM) || (op == LBS_OP_OR_IMM) ||
                 (op == LBS_OP_OUT_IMM);
    endfunction

    // state
    logic [IMG_BITS-1:0]     img_reg;
    logic [STACK_LEVELS-1:0] stk_reg;
    logic [STACK_LEVELS-1:0] stk_next;
    logic [DEPTH_W-1:0]      depth_reg;
    logic [DEPTH_W-1:0]      depth_next;
    logic                    new_rung_reg;
    logic                    err_reg;
    logic                    done_reg;
    logic                    ready_reg;
    logic [NUM_IN-1:0]       in_s1_reg;
    logic [NUM_IN-1:0]       in_s2_reg;
    logic [NUM_OUT-1:0]      out_reg;
    lbs_state_t              state_reg;
    lbs_op_t                 pend_op_reg;
    logic [ADDR_W-1:0]       pend_addr_reg;
    logic                    req_reg;
    logic                    wr_reg;
    logic                    wdata_reg;

    // decoded evaluation step
    logic    accept;
    logic    skip;
    logic    fire;
    lbs_op_t ev_op;
    logic    [ADDR_W-1:0] ev_addr;
    logic    ev_img;
    logic    cv;
    logic    err_set;
    logic    coil_wr;
    logic    start_imm;

    // an instruction is taken only while the program runs
    assign accept = instr_valid && ready_reg && (phase == LBS_PH_EXEC) &&
                    (state_reg == LBS_ST_IDLE);
    // after the end marker only separately entered routines run
    assign skip = done_reg && !instr_isr;
    // immediates do not evaluate until the module answers
    assign start_imm = accept && !skip && is_imm(instr_op);
    assign fire = (accept && !skip && !is_imm(instr_op)) ||
                  ((state_reg == LBS_ST_WAIT) && imm_ack);
    assign ev_op   = (state_reg == LBS_ST_WAIT) ? pend_op_reg : instr_op;
    assign ev_addr = (state_reg == LBS_ST_WAIT) ? pend_addr_reg : instr_addr;
    assign ev_img  = img_reg[ev_addr];

    // contact source: image for ordinary ops, module answer for immediates
    always_comb begin
        if (state_reg == LBS_ST_WAIT) begin
            cv = imm_rdata;
        end else begin
            cv = ev_img;
        end
    end

    // stack arithmetic for one evaluated instruction
    always_comb begin
        stk_next   = stk_reg;
        depth_next = depth_reg;
        err_set    = 1'b0;
        coil_wr    = 1'b0;
        if (fire) begin
            unique case (ev_op)
                LBS_OP_LOAD_CONTACT, LBS_OP_LOAD_INVERTED_CONTACT,
                LBS_OP_LOAD_IMM, LBS_OP_LOAD_INVERTED_IMM: begin
                    if (new_rung_reg) begin
                        // a fresh rung discards what the last one left
                        stk_next   = {{(STACK_LEVELS-1){1'b0}},
                                      contact(cv, ev_op == LBS_OP_LOAD_INVERTED_CONTACT ||
                                                  ev_op == LBS_OP_LOAD_INVERTED_IMM)};
                        depth_next = DEPTH_ONE;
                    end else if (depth_reg == DEPTH_MAX) begin
                        err_set = 1'b1;
                    end else begin
                        // push; older levels move one down
                        stk_next   = {stk_reg[STACK_LEVELS-2:0],
                                      contact(cv, ev_op == LBS_OP_LOAD_INVERTED_CONTACT ||
                                                  ev_op == LBS_OP_LOAD_INVERTED_IMM)};
                        depth_next = depth_reg + DEPTH_ONE;
                    end
                end
                LBS_OP_AND, LBS_OP_AND_NOT, LBS_OP_AND_IMM: begin
                    if (depth_reg == DEPTH_ZERO) begin
                        err_set = 1'b1;
                    end else begin
                        stk_next[0] = stk_reg[0] &
                                      contact(cv, ev_op == LBS_OP_AND_NOT);
                    end
                end
                LBS_OP_OR, LBS_OP_OR_NOT, LBS_OP_OR_IMM: begin
                    if (depth_reg == DEPTH_ZERO) begin
                        err_set = 1'b1;
                    end else begin
                        stk_next[0] = stk_reg[0] |
                                      contact(cv, ev_op == LBS_OP_OR_NOT);
                    end
                end
                LBS_OP_COMBINE_SERIES_LEVELS: begin
                    if (depth_reg < DEPTH_W'(2)) begin
                        err_set = 1'b1;
                    end else begin
                        stk_next   = {1'b0, stk_reg[STACK_LEVELS-1:2],
                                      stk_reg[1] & stk_reg[0]};
                        depth_next = depth_reg - DEPTH_ONE;
                    end
                end
                LBS_OP_COMBINE_PARALLEL_LEVELS: begin
                    if (depth_reg < DEPTH_W'(2)) begin
                        err_set = 1'b1;
                    end else begin
                        stk_next   = {1'b0, stk_reg[STACK_LEVELS-1:2],
                                      stk_reg[1] | stk_reg[0]};
                        depth_next = depth_reg - DEPTH_ONE;
                    end
                end
                LBS_OP_OUT, LBS_OP_OUT_IMM: begin
                    // the stack is left intact so the rung may go on
                    if (depth_reg == DEPTH_ZERO) begin
                        err_set = 1'b1;
                    end else begin
                        coil_wr = 1'b1;
                    end
                end
                LBS_OP_NOP, LBS_OP_END: begin
                    stk_next = stk_reg;
                end
            endcase
        end
    end

    // boolean stack and its depth
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            stk_reg   <= '0;
            depth_reg <= DEPTH_ZERO;
        end else if (phase == LBS_PH_IN_UPD) begin
            stk_reg   <= '0;
            depth_reg <= DEPTH_ZERO;
        end else begin
            stk_reg   <= stk_next;
            depth_reg <= depth_next;
        end
    end

    // a load right after a coil opens a new rung
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            new_rung_reg <= RST_HIGH;
        end else if (phase == LBS_PH_IN_UPD) begin
            new_rung_reg <= 1'b1;
        end else if (fire) begin
            new_rung_reg <= (ev_op == LBS_OP_OUT) || (ev_op == LBS_OP_OUT_IMM);
        end
    end

    // sticky stack error, cleared when a new scan starts
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            err_reg <= RST_LOW;
        end else if (err_set) begin
            err_reg <= 1'b1;
        end else if (phase == LBS_PH_IN_UPD) begin
            err_reg <= 1'b0;
        end
    end

    // end marker seen in this scan
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            done_reg <= RST_LOW;
        end else if (phase == LBS_PH_IN_UPD) begin
            done_reg <= 1'b0;
        end else if (accept && !instr_isr && instr_op == LBS_OP_END) begin
            done_reg <= 1'b1;
        end
    end

    // input pins pass two flops before use
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            in_s1_reg <= '0;
            in_s2_reg <= '0;
        end else begin
            in_s1_reg <= io_in;
            in_s2_reg <= in_s1_reg;
        end
    end

    // image register: input update, coil writes
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            img_reg <= '0;
        end else if (phase == LBS_PH_IN_UPD) begin
            img_reg[NUM_IN-1:0] <= in_s2_reg;
        end else if (coil_wr) begin
            // immediate output updates the image as well
            img_reg[ev_addr] <= stk_reg[0];
        end
    end

    // output pins change only in the output update phase
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            out_reg <= '0;
        end else if (phase == LBS_PH_OUT_UPD) begin
            out_reg <= img_reg[NUM_IN +: NUM_OUT];
        end
    end

    // immediate access sequencer; every immediate asks the module anew
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg     <= LBS_ST_IDLE;
            pend_op_reg   <= LBS_OP_NOP;
            pend_addr_reg <= '0;
            req_reg       <= RST_LOW;
            wr_reg        <= RST_LOW;
            wdata_reg     <= RST_LOW;
            ready_reg     <= RST_HIGH;
        end else begin
            unique case (state_reg)
                LBS_ST_IDLE: begin
                    if (start_imm) begin
                        state_reg     <= LBS_ST_WAIT;
                        pend_op_reg   <= instr_op;
                        pend_addr_reg <= instr_addr;
                        req_reg       <= 1'b1;
                        wr_reg        <= (instr_op == LBS_OP_OUT_IMM);
                        wdata_reg     <= stk_reg[0];
                        ready_reg     <= 1'b0;
                    end
                end
                LBS_ST_WAIT: begin
                    if (imm_ack) begin
                        state_reg <= LBS_ST_IDLE;
                        req_reg   <= 1'b0;
                        wr_reg    <= 1'b0;
                        ready_reg <= 1'b1;
                    end
                end
            endcase
        end
    end

    // outputs straight from flops
    assign instr_ready = ready_reg;
    assign rung_result = stk_reg[0];
    assign stack_err   = err_reg;
    assign prog_done   = done_reg;
    assign io_out      = out_reg;
    assign imm_req     = req_reg;
    assign imm_wr      = wr_reg;
    assign imm_addr    = pend_addr_reg;
    assign imm_wdata   = wdata_reg;

endmodule

// ==== lbs_chk.sv ====
// Purpose: port-level assertions for the boolean stack evaluator
// Assumes: single clock, async active-low reset
// Notes:   bound into every evaluator instance
`timescale 1ns/100ps

module lbs_chk
    import lbs_pkg::*;
#(
    parameter int ADDR_W  = lbs_pkg::ADDR_W,
    parameter int NUM_IN  = lbs_pkg::NUM_IN,
    parameter int NUM_OUT = lbs_pkg::NUM_OUT
) (
    // clock and reset
    input wire logic                clk,
    input wire logic                rst_b,
    // instruction side
    input wire lbs_pkg::lbs_phase_t phase,
    input wire logic                instr_valid,
    input wire lbs_pkg::lbs_op_t    instr_op,
    input wire logic [ADDR_W-1:0]   instr_addr,
    input wire logic                instr_isr,
    input wire logic                instr_ready,
    input wire logic                rung_result,
    input wire logic                stack_err,
    input wire logic                prog_done,
    // pins and module link
    input wire logic [NUM_IN-1:0]   io_in,
    input wire logic [NUM_OUT-1:0]  io_out,
    input wire logic                imm_req,
    input wire logic                imm_wr,
    input wire logic [ADDR_W-1:0]   imm_addr,
    input wire logic                imm_wdata,
    input wire logic                imm_ack,
    input wire logic                imm_rdata
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    logic     taken;
    lbs_op_t  op_reg;

    // remember the op of the last take; immediates are judged against it
    assign taken = instr_valid && instr_ready && phase == LBS_PH_EXEC;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) op_reg <= LBS_OP_NOP;
        else if (taken) op_reg <= instr_op;
    end

    chk_imm_launch: assert property (taken && (!prog_done || instr_isr) &&
        instr_op inside {[LBS_OP_LOAD_IMM:LBS_OP_OUT_IMM]} |=> imm_req && !instr_ready)
        else $error("immediate op did not start a module access");
    chk_ord_no_io: assert property (taken &&
        !(instr_op inside {[LBS_OP_LOAD_IMM:LBS_OP_OUT_IMM]}) |=> !imm_req)
        else $error("ordinary op touched the module");
    chk_req_holds: assert property (imm_req && !imm_ack |=> imm_req &&
        $stable(imm_addr) && $stable(imm_wr) && $stable(imm_wdata))
        else $error("module request changed before ack");
    chk_req_drops: assert property (imm_req && imm_ack |=> !imm_req && instr_ready)
        else $error("access did not end after ack");
    chk_stall_ready: assert property (imm_req |-> !instr_ready)
        else $error("ready high during module access");
    chk_imm_read: assert property (imm_req && imm_ack && !imm_wr &&
        op_reg inside {LBS_OP_LOAD_IMM, LBS_OP_LOAD_INVERTED_IMM} |=>
        rung_result == ($past(imm_rdata) ^ (op_reg == LBS_OP_LOAD_INVERTED_IMM)))
        else $error("immediate load result wrong");
    chk_write_kind: assert property (imm_req |->
        imm_wr == (op_reg == LBS_OP_OUT_IMM)) else $error("access direction wrong");
    chk_write_data: assert property (imm_req && imm_wr |->
        imm_wdata == rung_result) else $error("immediate write data wrong");
    chk_pins_hold: assert property (phase != LBS_PH_OUT_UPD |=> $stable(io_out))
        else $error("output pins moved outside output update");
    chk_end_flag: assert property (taken && instr_op == LBS_OP_END && !instr_isr
        |=> prog_done) else $error("end not flagged");
    chk_inupd_clear: assert property (phase == LBS_PH_IN_UPD |=>
        !stack_err && !prog_done) else $error("flags not cleared in input update");
endmodule

bind lbs_evaluator lbs_chk #(.ADDR_W(ADDR_W), .NUM_IN(NUM_IN), .NUM_OUT(NUM_OUT)) i_chk (
    .clk, .rst_b, .phase, .instr_valid, .instr_op, .instr_addr, .instr_isr, .instr_ready,
    .rung_result, .stack_err, .prog_done, .io_in, .io_out, .imm_req, .imm_wr,
    .imm_addr, .imm_wdata, .imm_ack, .imm_rdata);

// ==== lbs_io_model.sv ====
// Purpose: behavioural I/O module answering immediate accesses
// Assumes: same clock as the evaluator
// Notes:   pts is loaded by the bench directly; dly sets answer speed
`timescale 1ns/100ps

module lbs_io_model (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_b,
    // module link
    input  wire logic       imm_req,
    input  wire logic       imm_wr,
    input  wire logic [7:0] imm_addr,
    input  wire logic       imm_wdata,
    input  wire logic [3:0] dly,
    output      logic       imm_ack,
    output      logic       imm_rdata
);
    logic [255:0] pts = '0;
    logic [3:0]   cnt;
    logic         tog;

    // one ack pulse per request after dly waiting cycles
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt     <= 4'h0;
            imm_ack <= 1'b0;
            tog     <= 1'b0;
        end else begin
            tog     <= ~tog;
            imm_ack <= 1'b0;
            if (imm_req && !imm_ack) begin
                if (cnt >= dly) begin
                    imm_ack <= 1'b1;
                    cnt     <= 4'h0;
                end else cnt <= cnt + 4'h1;
            end
        end
    end

    // plain always: the bench also loads points, so not always_ff
    always @(posedge clk) begin
        if (imm_req && imm_ack && imm_wr) pts[imm_addr] <= imm_wdata;
    end

    // live status only in the ack cycle; toggling otherwise so stale data shows
    assign imm_rdata = imm_ack ? pts[imm_addr] : tog;
endmodule

// ==== lbs_tb.sv ====
// Purpose: self-checking bench for the boolean stack evaluator
// Assumes: inputs change 1 ns after the rising edge
// Notes:   scenarios are tasks; each ends with one summary line
`timescale 1ns/100ps

module tb;
    import lbs_pkg::*;
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end

    logic        clk = 0, rst_b = 0, instr_valid = 0, instr_isr = 0;
    lbs_phase_t  phase = LBS_PH_IDLE;
    lbs_op_t     instr_op = LBS_OP_NOP;
    logic [7:0]  instr_addr = 8'h00, imm_addr;
    logic [63:0] io_in = 64'h0, io_out;
    logic [3:0]  dly = 4'h0;
    logic        instr_ready, rung_result, stack_err, prog_done;
    logic        imm_req, imm_wr, imm_wdata, imm_ack, imm_rdata;
    int          errors = 0, checks = 0, lat;

    always #2 clk = ~clk;

    lbs_evaluator i_dut (.clk, .rst_b, .phase, .instr_valid, .instr_op, .instr_addr,
        .instr_isr, .instr_ready, .rung_result, .stack_err, .prog_done, .io_in, .io_out,
        .imm_req, .imm_wr, .imm_addr, .imm_wdata, .imm_ack, .imm_rdata);
    lbs_io_model i_io (.clk, .rst_b, .imm_req, .imm_wr, .imm_addr, .imm_wdata, .dly,
        .imm_ack, .imm_rdata);

    task automatic step(int n);
        repeat (n) begin @(posedge clk); #1; end
    endtask
    // phase change also withdraws any pending instruction
    task automatic go(lbs_phase_t p, int n);
        instr_valid = 0; phase = p; step(n);
    endtask
    // issue one op, then wait for ready; lat counts the stall
    task automatic op(lbs_op_t o, logic [7:0] a, logic isr = 1'b0);
        instr_valid = 1; instr_op = o; instr_addr = a; instr_isr = isr; step(1);
        lat = 0;
        while (instr_ready !== 1'b1 && lat < 50) begin step(1); lat++; end
        // a stall past the limit is a hang: count it and close the run
        if (lat >= 50) begin
            errors++;
            report_and_stop;
        end
    endtask

    task automatic t_rung;
        io_in = 64'h5; go(LBS_PH_IN_UPD, 4); go(LBS_PH_EXEC, 0);
        op(LBS_OP_LOAD_CONTACT, 0); `CHK(rung_result, 1'b1)
        op(LBS_OP_LOAD_CONTACT, 3); `CHK(rung_result, 1'b0)
        op(LBS_OP_COMBINE_PARALLEL_LEVELS, 0); `CHK(rung_result, 1'b1)
        op(LBS_OP_LOAD_CONTACT, 1); op(LBS_OP_COMBINE_SERIES_LEVELS, 0);
        `CHK(rung_result, 1'b0)
        op(LBS_OP_OR, 2); `CHK(rung_result, 1'b1)
        op(LBS_OP_OUT, 8'h40); op(LBS_OP_AND, 3); `CHK(rung_result, 1'b0)
        op(LBS_OP_OUT, 8'h41); op(LBS_OP_LOAD_INVERTED_CONTACT, 3);
        `CHK(rung_result, 1'b1)
        op(LBS_OP_AND_NOT, 0); `CHK(rung_result, 1'b0)
        op(LBS_OP_OR_NOT, 1); `CHK(rung_result, 1'b1)
        op(LBS_OP_OUT, 8'h42); go(LBS_PH_EXEC, 2); `CHK(io_out[2:0], 3'h0)
        go(LBS_PH_OUT_UPD, 2); `CHK(io_out[2:0], 3'h5)
        `CHK(stack_err, 1'b0)
        $display("t_rung done");
    endtask

    task automatic t_over;
        go(LBS_PH_IN_UPD, 2); go(LBS_PH_EXEC, 0);
        repeat (8) op(LBS_OP_LOAD_CONTACT, 0);
        `CHK(stack_err, 1'b0)
        op(LBS_OP_OUT, 8'h43);
        repeat (8) op(LBS_OP_LOAD_INVERTED_CONTACT, 0);
        `CHK(stack_err, 1'b0)
        op(LBS_OP_LOAD_CONTACT, 0); `CHK(stack_err, 1'b1)
        go(LBS_PH_IN_UPD, 2); `CHK(stack_err, 1'b0)
        // combining with too few levels must also flag the error
        go(LBS_PH_EXEC, 0);
        op(LBS_OP_COMBINE_SERIES_LEVELS, 0); `CHK(stack_err, 1'b1)
        go(LBS_PH_IN_UPD, 2);
        $display("t_over done");
    endtask

    task automatic t_imm;
        go(LBS_PH_EXEC, 0); i_io.pts[5] = 1; i_io.pts[6] = 1; dly = 4'h0;
        op(LBS_OP_LOAD_IMM, 5); `CHK(rung_result, 1'b1)
        `CHK(lat, 2)
        op(LBS_OP_LOAD_CONTACT, 5); `CHK(rung_result, 1'b0)
        i_io.pts[5] = 0; dly = 4'h4;
        op(LBS_OP_LOAD_INVERTED_IMM, 5); `CHK(rung_result, 1'b1)
        `CHK(lat, 6)
        op(LBS_OP_LOAD_CONTACT, 0); op(LBS_OP_AND_IMM, 5); `CHK(rung_result, 1'b0)
        op(LBS_OP_OR_IMM, 6); `CHK(rung_result, 1'b1)
        op(LBS_OP_OUT_IMM, 8'h46); `CHK(i_io.pts[70], 1'b1)
        op(LBS_OP_LOAD_CONTACT, 8'h46); `CHK(rung_result, 1'b1)
        go(LBS_PH_OUT_UPD, 2); `CHK(io_out[6], 1'b1)
        $display("t_imm done");
    endtask

    task automatic t_end;
        go(LBS_PH_IN_UPD, 2); go(LBS_PH_EXEC, 0);
        op(LBS_OP_LOAD_CONTACT, 0); op(LBS_OP_END, 0); `CHK(prog_done, 1'b1)
        op(LBS_OP_OUT, 8'h47); op(LBS_OP_LOAD_CONTACT, 0, 1'b1); op(LBS_OP_OUT, 8'h48, 1'b1);
        go(LBS_PH_OUT_UPD, 2); `CHK(io_out[8:7], 2'h2)
        go(LBS_PH_IN_UPD, 2); `CHK(prog_done, 1'b0)
        $display("t_end done");
    endtask

    task automatic report_and_stop;
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // main sequence after a 20-cycle reset
    initial begin
        repeat (20) @(posedge clk);
        #1 rst_b = 1;
        t_rung; t_over; t_imm; t_end;
        report_and_stop;
    end

    // watchdog: the tests need well under a thousand cycles
    initial begin
        #(4 * 5000);
        errors++;
        report_and_stop;
    end
endmodule
